// *** dv/mcr_host_model.sv ***
`timescale 1ns/1ps
module mcr_host_model
  import mcr_pkg::*;
(
  // clock
  input wire logic       clock,
  // register port
  output logic           reg_wr,
  output logic           reg_rd,
  output logic [4:0]     reg_addr,
  output mcr_word_t      reg_wdata,
  input wire mcr_word_t  reg_rdata,
  input wire logic       reg_rvalid
);
  logic tmo;
  initial begin
    tmo = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 5'h00;
    reg_wdata = 24'h000000;
  end
  task automatic wr(input logic [4:0] a, input mcr_word_t d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr
  // answer is awaited a few cycles only; a missing one flags a timeout
  task automatic rd(input logic [4:0] a, output mcr_word_t d);
    int i;
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    d = 'x;
    for (i = 0; i < 4; i++) begin
      #1;
      if (reg_rvalid === 1'b1) break;
      @(posedge clock);
    end
    if (i == 4) tmo = 1'b1;
    else d = reg_rdata;
  endtask : rd
endmodule : mcr_host_model

// *** dv/mcr_regbank_sva.sv ***
`timescale 1ns/1ps
module mcr_regbank_sva
  import mcr_pkg::*;
(
  // clock and reset
  input wire logic       clock,
  input wire logic       reset,
  // register port
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [4:0] reg_addr,
  input wire mcr_word_t  reg_wdata,
  input wire logic       reg_rvalid,
  // control outputs
  input wire logic       autoboot_stop,
  input wire logic       int_open_drain,
  input wire logic       host_clock_off,
  input wire logic       oscillator_off,
  input wire logic [6:0] page_select
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  logic ctl_wr;
  logic pg_wr;
  assign ctl_wr = reg_wr && reg_addr == 5'h1C && page_select == 7'h00;
  assign pg_wr  = reg_wr && reg_addr == 5'h1F;
  chk_read_answer: assert property (reg_rd |=> reg_rvalid)
    else $error("read got no answer");
  chk_read_source: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("answer without read");
  chk_stop_bit: assert property (ctl_wr |=> autoboot_stop == $past(reg_wdata[8]))
    else $error("stop bit wrong");
  chk_open_drain: assert property (ctl_wr |=> int_open_drain == $past(reg_wdata[4]))
    else $error("open drain bit wrong");
  chk_cpu_clock: assert property (ctl_wr |=> host_clock_off == $past(reg_wdata[2]))
    else $error("clock off bit wrong");
  chk_osc_off: assert property (ctl_wr |=> oscillator_off == $past(reg_wdata[1]))
    else $error("oscillator bit wrong");
  chk_page_load: assert property (pg_wr |=> page_select == $past(reg_wdata[6:0]))
    else $error("page not loaded");
  chk_page_hold: assert property (!pg_wr |=> $stable(page_select))
    else $error("page changed unasked");
endmodule : mcr_regbank_sva
bind mcr_regbank mcr_regbank_sva u_sva (.*);

// *** dv/mcr_regbank_tb.sv ***
`timescale 1ns/1ps
module mcr_regbank_tb
  import mcr_pkg::*;
;
  logic       clock = 1'b0;
  logic       reset = 1'b1;
  logic       reg_wr, reg_rd, reg_rvalid, volt_sag_event, curr_fault_event;
  logic       autoboot_stop, int_open_drain, host_clock_off, oscillator_off;
  logic       sample_strobe = 1'b0;
  logic       result_strobe = 1'b0;
  logic [4:0] reg_addr;
  logic [6:0] page_select;
  mcr_word_t  reg_wdata, reg_rdata, volt_comp, curr_comp, volt_rms, curr_rms, temp_out, d;
  mcr_word_t  volt_sample = 24'h200000;
  mcr_word_t  curr_sample = 24'h200000;
  mcr_word_t  volt_gain = 24'h400000;
  mcr_word_t  curr_gain = 24'h400000;
  mcr_word_t  volt_dc_offset = 24'h000000;
  mcr_word_t  curr_dc_offset = 24'h100000;
  mcr_word_t  volt_rms_raw = 24'h300000;
  mcr_word_t  curr_rms_raw = 24'h300000;
  mcr_word_t  volt_ac_offset = 24'h100000;
  mcr_word_t  curr_ac_offset = 24'h000000;
  // raw temperature equal to minus the default offset
  mcr_word_t  temp_raw = 24'h0C1830;
  mcr_word_t  active_power = 24'h300000;
  mcr_word_t  dft_volt_re = 24'h400000;
  mcr_word_t  dft_volt_im = 24'hC00000;
  mcr_word_t  dft_curr_re = 24'h400000;
  int         n_fail = 0;
  int         num_checks = 0;
  int         n_sag = 0;
  int         n_flt = 0;
  mcr_regbank dut (.*);
  mcr_host_model host (.*);
  always #2.5 clock = ~clock;
  always @(posedge clock) begin
    n_sag <= n_sag + int'(volt_sag_event === 1'b1);
    n_flt <= n_flt + int'(curr_fault_event === 1'b1);
  end
  task automatic stop_test;
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  task automatic chk(input mcr_word_t got, input mcr_word_t exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
    if (host.tmo) stop_test();
  endtask : chk
  task automatic rdc(input logic [4:0] a, input mcr_word_t exp);
    host.rd(a, d);
    chk(d, exp);
  endtask : rdc
  task automatic smp(input int n);
    repeat (n) begin
      @(posedge clock);
      sample_strobe <= 1'b1;
      @(posedge clock);
      sample_strobe <= 1'b0;
      repeat (2) @(posedge clock);
    end
  endtask : smp
  initial begin
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    rdc(5'h1C, 24'h000000);
    chk(24'(page_select), 24'h000000);
    rdc(5'h05, 24'h000000);
    $display("test reset done");
    host.wr(5'h1F, 24'h000001);
    rdc(5'h02, 24'h34E2E7);
    chk(24'(page_select), 24'h000001);
    rdc(5'h03, 24'hF3E7D0);
    host.wr(5'h02, 24'h123456);
    rdc(5'h02, 24'h123456);
    $display("test temperature done");
    host.wr(5'h1F, 24'h000003);
    rdc(5'h06, 24'h000000);
    rdc(5'h07, 24'h000000);
    rdc(5'h0A, 24'h000000);
    rdc(5'h0B, 24'h000000);
    rdc(5'h02, 24'h000000);
    host.wr(5'h06, 24'h000002);
    host.wr(5'h07, 24'h100000);
    rdc(5'h07, 24'h100000);
    smp(2);
    chk(24'(n_sag), 24'h000001);
    chk(24'(n_flt), 24'h000000);
    // offset cancels the raw reading, so any gain gives zero
    chk(temp_out, 24'h000000);
    host.wr(5'h07, 24'h010000);
    smp(2);
    chk(24'(n_sag), 24'h000001);
    chk(volt_comp, 24'h100000);
    chk(curr_comp, 24'h180000);
    chk(volt_rms, 24'h200000);
    chk(curr_rms, 24'h300000);
    // level 0.1875 sits above the mean of 0.125 only with three integer bits
    host.wr(5'h07, 24'h060000);
    smp(2);
    chk(24'(n_sag), 24'h000002);
    host.wr(5'h0A, 24'h000001);
    host.wr(5'h0B, 24'h100000);
    smp(1);
    chk(24'(n_flt), 24'h000001);
    $display("test sag done");
    host.wr(5'h1F, 24'h000000);
    host.wr(5'h1C, 24'h000100);
    rdc(5'h1C, 24'h000100);
    chk(24'({autoboot_stop, int_open_drain, host_clock_off, oscillator_off}), 24'h000008);
    host.wr(5'h1C, 24'h000010);
    rdc(5'h1C, 24'h000010);
    chk(24'({autoboot_stop, int_open_drain, host_clock_off, oscillator_off}), 24'h000004);
    host.wr(5'h1C, 24'h000004);
    rdc(5'h1C, 24'h000004);
    chk(24'({autoboot_stop, int_open_drain, host_clock_off, oscillator_off}), 24'h000002);
    host.wr(5'h1C, 24'h000002);
    rdc(5'h1C, 24'h000002);
    chk(24'({autoboot_stop, int_open_drain, host_clock_off, oscillator_off}), 24'h000001);
    $display("test control done");
    @(posedge clock);
    result_strobe <= 1'b1;
    @(posedge clock);
    result_strobe <= 1'b0;
    rdc(5'h1D, 24'h100000);
    rdc(5'h1E, 24'h200000);
    rdc(5'h1F, 24'hE00000);
    host.wr(5'h1D, 24'h5A5A5A);
    rdc(5'h1D, 24'h100000);
    $display("test results done");
    stop_test();
  end
endmodule : mcr_regbank_tb

// *** logic/mcr_params.svh ***
`ifndef MCR_PARAMS_SVH
`define MCR_PARAMS_SVH
// register addresses (5-bit serial port address within a page)
`define MCR_ADDR_TEMP_GAIN      5'h02
`define MCR_ADDR_TEMP_OFFSET    5'h03
`define MCR_ADDR_VOLTAGE_SAG_DURATION  5'h06
`define MCR_ADDR_VOLTAGE_SAG_LEVEL     5'h07
`define MCR_ADDR_IFLT_DURATION  5'h0A
`define MCR_ADDR_IFLT_LEVEL     5'h0B
`define MCR_ADDR_CONTROL        5'h1C
`define MCR_ADDR_HARM_P         5'h1D
`define MCR_ADDR_FUND_P         5'h1E
`define MCR_ADDR_FUND_Q_PAGE    5'h1F
// pages
`define MCR_PAGE_0              7'h00
`define MCR_PAGE_1              7'h01
`define MCR_PAGE_3              7'h03
// control bit positions
`define MCR_CTRL_STOP_BIT       8
`define MCR_CTRL_INT_OD_BIT     4
`define MCR_CTRL_CPU_OFF_BIT    2
`define MCR_CTRL_OSC_OFF_BIT    1
// reset values
`define MCR_RST_CONTROL         24'h000000
`define MCR_RST_PAGE            7'h00
`define MCR_RST_TEMP_GAIN       24'h34E2E7
`define MCR_RST_TEMP_OFFSET     24'hF3E7D0
`define MCR_RST_SAG             24'h000000
// memory of page registers
`define MCR_MEM_DEPTH           8
`endif

// *** logic/mcr_pkg.sv ***
package mcr_pkg;
  typedef logic [23:0] mcr_word_t;
  typedef enum logic [2:0] {
    MCR_SLOT_TEMPERATURE_GAIN, MCR_SLOT_TEMPERATURE_OFFSET, MCR_SLOT_VDUR, MCR_SLOT_VLVL,
    MCR_SLOT_IDUR, MCR_SLOT_ILVL, MCR_SLOT_NONE0, MCR_SLOT_NONE1
  } mcr_slot_t;
endpackage : mcr_pkg

// *** logic/mcr_regbank.sv ***
`timescale 1ns/1ps
`include "mcr_params.svh"
// Summary of operation
// - control bit 8 write stops auto-boot
// - control bit 4 makes interrupt open drain
// - control bit 2 stops host clock output
// - control bit 1 turns oscillator off
// - harmonic power is active minus fundamental
// - fundamental power is product of DFTs
// - address 31 reads reactive on page 0, writes page
// - seven-bit page select resets to zero
// - temperature gain signed, reset 0x34E2E7
// - temperature gain scales temperature reading
// - temperature offset cancels zero-degree offset
// - duration registers count samples per channel
// - zero duration disables that channel's detection
// - mean magnitude below level flags event
// - levels unsigned, point after third bit
// - DC offset/gain on samples, AC on RMS
// - separate calibration per channel
module mcr_regbank
  import mcr_pkg::*;
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        reset,
  // register access from the serial port engine
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [4:0]  reg_addr,
  input  wire mcr_word_t   reg_wdata,
  output mcr_word_t        reg_rdata,
  output logic             reg_rvalid,
  // measurement datapath inputs (signed fractions)
  input  wire logic        sample_strobe,
  input  wire mcr_word_t   volt_sample,
  input  wire mcr_word_t   curr_sample,
  input  wire mcr_word_t   volt_gain,
  input  wire mcr_word_t   volt_dc_offset,
  input  wire mcr_word_t   curr_gain,
  input  wire mcr_word_t   curr_dc_offset,
  input  wire mcr_word_t   volt_rms_raw,
  input  wire mcr_word_t   curr_rms_raw,
  input  wire mcr_word_t   volt_ac_offset,
  input  wire mcr_word_t   curr_ac_offset,
  input  wire mcr_word_t   temp_raw,
  input  wire logic        result_strobe,
  input  wire mcr_word_t   active_power,
  input  wire mcr_word_t   dft_volt_re,
  input  wire mcr_word_t   dft_volt_im,
  input  wire mcr_word_t   dft_curr_re,
  // compensated outputs
  output mcr_word_t        volt_comp,
  output mcr_word_t        curr_comp,
  output mcr_word_t        volt_rms,
  output mcr_word_t        curr_rms,
  output mcr_word_t        temp_out,
  // sag and fault flags, one-cycle pulses
  output logic             volt_sag_event,
  output logic             curr_fault_event,
  // control outputs
  output logic             autoboot_stop,
  output logic             int_open_drain,
  output logic             host_clock_off,
  output logic             oscillator_off,
  output logic [6:0]       page_select
);
  typedef struct packed {
    mcr_word_t  ctrl;
    logic [6:0] page;
    mcr_word_t  harm_p;
    mcr_word_t  fund_p;
    mcr_word_t  fund_q;
    mcr_word_t  rdata;
    logic       rvalid;
    logic       mem_sel;
    mcr_word_t  v_comp;
    mcr_word_t  i_comp;
    mcr_word_t  v_rms;
    mcr_word_t  i_rms;
    mcr_word_t  t_out;
    logic [23:0] v_cnt;
    logic [23:0] i_cnt;
    logic [47:0] v_acc;
    logic [47:0] i_acc;
    logic       v_evt;
    logic       i_evt;
  } mcr_state_t;

  mcr_state_t st_r;
  mcr_state_t st_nxt;

  // page register memory
  logic       mem_wr;
  logic [2:0] mem_waddr;
  logic [2:0] mem_raddr;
  logic       mem_hit;
  mcr_word_t  mem_rdata;
  mcr_word_t  mem_q [`MCR_MEM_DEPTH];

  mcr_regmem u_mem (
    .clock   (clock),
    .reset   (reset),
    .wr_en   (mem_wr),
    .wr_addr (mem_waddr),
    .wr_data (reg_wdata),
    .rd_addr (mem_raddr),
    .rd_data (mem_rdata),
    .all_q   (mem_q)
  );

  // map page/address onto a memory slot; page held until rewritten
  always_comb begin
    mem_hit   = 1'b1;
    mem_raddr = MCR_SLOT_NONE0;
    if (st_r.page == `MCR_PAGE_1 && reg_addr == `MCR_ADDR_TEMP_GAIN) begin
      mem_raddr = MCR_SLOT_TEMPERATURE_GAIN;
    end else if (st_r.page == `MCR_PAGE_1 && reg_addr == `MCR_ADDR_TEMP_OFFSET) begin
      mem_raddr = MCR_SLOT_TEMPERATURE_OFFSET;
    end else if (st_r.page == `MCR_PAGE_3 && reg_addr == `MCR_ADDR_VOLTAGE_SAG_DURATION) begin
      mem_raddr = MCR_SLOT_VDUR;
    end else if (st_r.page == `MCR_PAGE_3 && reg_addr == `MCR_ADDR_VOLTAGE_SAG_LEVEL) begin
      mem_raddr = MCR_SLOT_VLVL;
    end else if (st_r.page == `MCR_PAGE_3 && reg_addr == `MCR_ADDR_IFLT_DURATION) begin
      mem_raddr = MCR_SLOT_IDUR;
    end else if (st_r.page == `MCR_PAGE_3 && reg_addr == `MCR_ADDR_IFLT_LEVEL) begin
      mem_raddr = MCR_SLOT_ILVL;
    end else begin
      mem_hit = 1'b0;
    end
    mem_waddr = mem_raddr;
    mem_wr    = reg_wr && mem_hit;
  end

  // signed fraction helpers
  function automatic mcr_word_t mul_frac(input mcr_word_t a, input mcr_word_t b);
    logic signed [47:0] p;
    p = $signed(a) * $signed(b);
    return p[46:23];
  endfunction : mul_frac

  function automatic mcr_word_t mag(input mcr_word_t a);
    return a[23] ? mcr_word_t'(~a + 24'h000001) : a;
  endfunction : mag

  // a sagging window ends when the count reaches the duration
  function automatic logic sag_hit(input logic [47:0] acc, input mcr_word_t dur,
                                   input mcr_word_t lvl);
    logic [71:0] lhs;
    logic [71:0] rhs;
    // level has three integer bits, sample magnitudes one: scale level by 4
    lhs = {24'h000000, acc};
    rhs = {24'h000000, dur} * {48'h000000000000, lvl} * 72'h4;
    return lhs < rhs;
  endfunction : sag_hit

  always_comb begin
    mcr_word_t vc;
    mcr_word_t ic;
    mcr_word_t vdur;
    mcr_word_t idur;
    vc   = '0;
    ic   = '0;
    vdur = mem_q[MCR_SLOT_VDUR];
    idur = mem_q[MCR_SLOT_IDUR];
    st_nxt        = st_r;
    st_nxt.rvalid = reg_rd;
    st_nxt.v_evt  = 1'b0;
    st_nxt.i_evt  = 1'b0;

    // register writes
    if (reg_wr && st_r.page == `MCR_PAGE_0) begin
      if (reg_addr == `MCR_ADDR_CONTROL) begin
        st_nxt.ctrl = reg_wdata;
      end
    end
    if (reg_wr && reg_addr == `MCR_ADDR_FUND_Q_PAGE) begin
      st_nxt.page = reg_wdata[6:0];
    end

    // register reads: control and result registers on page 0, others from memory
    if (reg_rd) begin
      st_nxt.mem_sel = mem_hit;
      st_nxt.rdata   = '0;
      if (st_r.page == `MCR_PAGE_0) begin
        case (reg_addr)
          `MCR_ADDR_CONTROL:     st_nxt.rdata = st_r.ctrl;
          `MCR_ADDR_HARM_P:      st_nxt.rdata = st_r.harm_p;
          `MCR_ADDR_FUND_P:      st_nxt.rdata = st_r.fund_p;
          `MCR_ADDR_FUND_Q_PAGE: st_nxt.rdata = st_r.fund_q;
          default:               st_nxt.rdata = '0;
        endcase
      end
    end

    // power results
    if (result_strobe) begin
      st_nxt.fund_p = mul_frac(dft_volt_re, dft_curr_re);
      st_nxt.fund_q = mul_frac(dft_volt_im, dft_curr_re);
      st_nxt.harm_p = active_power - mul_frac(dft_volt_re, dft_curr_re);
    end

    // per-channel compensation, each from its own registers
    if (sample_strobe) begin
      vc = mul_frac(volt_sample + volt_dc_offset, volt_gain);
      ic = mul_frac(curr_sample + curr_dc_offset, curr_gain);
      st_nxt.v_comp = vc;
      st_nxt.i_comp = ic;
      st_nxt.v_rms  = volt_rms_raw - volt_ac_offset;
      st_nxt.i_rms  = curr_rms_raw - curr_ac_offset;
      st_nxt.t_out  = mul_frac(temp_raw + mem_q[MCR_SLOT_TEMPERATURE_OFFSET], mem_q[MCR_SLOT_TEMPERATURE_GAIN]);

      // sag window: zero duration keeps detection idle
      if (vdur == '0) begin
        st_nxt.v_cnt = '0;
        st_nxt.v_acc = '0;
      end else if (st_r.v_cnt + 24'h000001 >= vdur) begin
        st_nxt.v_evt = sag_hit(st_r.v_acc + {24'h000000, mag(vc)}, vdur,
                               mem_q[MCR_SLOT_VLVL]);
        st_nxt.v_cnt = '0;
        st_nxt.v_acc = '0;
      end else begin
        st_nxt.v_cnt = st_r.v_cnt + 24'h000001;
        st_nxt.v_acc = st_r.v_acc + {24'h000000, mag(vc)};
      end
      if (idur == '0) begin
        st_nxt.i_cnt = '0;
        st_nxt.i_acc = '0;
      end else if (st_r.i_cnt + 24'h000001 >= idur) begin
        st_nxt.i_evt = sag_hit(st_r.i_acc + {24'h000000, mag(ic)}, idur,
                               mem_q[MCR_SLOT_ILVL]);
        st_nxt.i_cnt = '0;
        st_nxt.i_acc = '0;
      end else begin
        st_nxt.i_cnt = st_r.i_cnt + 24'h000001;
        st_nxt.i_acc = st_r.i_acc + {24'h000000, mag(ic)};
      end
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      st_r      <= '0;
      st_r.ctrl <= `MCR_RST_CONTROL;
      st_r.page <= `MCR_RST_PAGE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata        = st_r.mem_sel ? mem_rdata : st_r.rdata;
  assign reg_rvalid       = st_r.rvalid;
  assign volt_comp        = st_r.v_comp;
  assign curr_comp        = st_r.i_comp;
  assign volt_rms         = st_r.v_rms;
  assign curr_rms         = st_r.i_rms;
  assign temp_out         = st_r.t_out;
  assign volt_sag_event   = st_r.v_evt;
  assign curr_fault_event = st_r.i_evt;
  assign autoboot_stop    = st_r.ctrl[`MCR_CTRL_STOP_BIT];
  assign int_open_drain   = st_r.ctrl[`MCR_CTRL_INT_OD_BIT];
  assign host_clock_off   = st_r.ctrl[`MCR_CTRL_CPU_OFF_BIT];
  assign oscillator_off   = st_r.ctrl[`MCR_CTRL_OSC_OFF_BIT];
  assign page_select      = st_r.page;
endmodule : mcr_regbank

// *** logic/mcr_regmem.sv ***
`timescale 1ns/1ps
`include "mcr_params.svh"
// small register memory; registered read port, write-first not needed
module mcr_regmem
  import mcr_pkg::*;
(
  // clock and reset
  input  wire logic      clock,
  input  wire logic      reset,
  // write port
  input  wire logic      wr_en,
  input  wire logic [2:0] wr_addr,
  input  wire mcr_word_t wr_data,
  // read port
  input  wire logic [2:0] rd_addr,
  output mcr_word_t      rd_data,
  // all contents for the datapath
  output mcr_word_t      all_q [`MCR_MEM_DEPTH]
);
  typedef struct packed {
    mcr_word_t [`MCR_MEM_DEPTH-1:0] mem;
    mcr_word_t                      rd;
  } mcr_mem_state_t;

  mcr_mem_state_t st_r;
  mcr_mem_state_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (wr_en) begin
      st_nxt.mem[wr_addr] = wr_data;
    end
    st_nxt.rd = st_r.mem[rd_addr];
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      st_r                         <= '0;
      st_r.mem[MCR_SLOT_TEMPERATURE_GAIN]     <= `MCR_RST_TEMP_GAIN;
      st_r.mem[MCR_SLOT_TEMPERATURE_OFFSET]      <= `MCR_RST_TEMP_OFFSET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rd_data = st_r.rd;

  genvar g;
  generate
    for (g = 0; g < `MCR_MEM_DEPTH; g++) begin : g_out
      assign all_q[g] = st_r.mem[g];
    end
  endgenerate
endmodule : mcr_regmem
